// >>> rtl/glc_consts.svh
// Offsets, field positions and default values of the genlock loop register bank
`ifndef GLC_CONSTS_SVH
`define GLC_CONSTS_SVH

// Register word indices; byte address is four times the index
`define GLC_IDX_UPDATE 6'h16
`define GLC_IDX_NUM_LO 6'h20
`define GLC_IDX_NUM_HI 6'h21
`define GLC_IDX_DEN_LO 6'h22
`define GLC_IDX_DEN_HI 6'h23
`define GLC_IDX_CTRL 6'h24
`define GLC_IDX_RESERVED_SLOT 6'h25
`define GLC_IDX_STD 6'h30
`define GLC_IDX_STAT 6'h31
`define GLC_IDX_MASK 6'h32

// Field positions
`define GLC_UPD_BIT 6
`define GLC_CRASH_MSB 15
`define GLC_CRASH_LSB 8
`define GLC_THR_MSB 7
`define GLC_THR_LSB 3
`define GLC_TOL_MSB 2
`define GLC_TOL_LSB 0

// Status event bits
`define GLC_EV_APPLIED 0
`define GLC_EV_CRASH_DONE 1
`define GLC_EV_LOCK_LOST 2
`define GLC_EV_REJECT 3

// Standard selected at reset
`define GLC_STD_RST 2'h0

// Per-standard defaults: numerator, denominator, control word
`define GLC_DEF_NUM_0 32'h0000_0001
`define GLC_DEF_DEN_0 32'h0000_0001
`define GLC_DEF_CTRL_0 16'h0a52
`define GLC_DEF_NUM_1 32'h0000_000b
`define GLC_DEF_DEN_1 32'h0000_000a
`define GLC_DEF_CTRL_1 16'h0842
`define GLC_DEF_NUM_2 32'h0000_0004
`define GLC_DEF_DEN_2 32'h0000_0003
`define GLC_DEF_CTRL_2 16'h0c62
`define GLC_DEF_NUM_3 32'h0000_0002
`define GLC_DEF_DEN_3 32'h0000_0001
`define GLC_DEF_CTRL_3 16'h1041

`endif

// >>> rtl/glc_pkg.sv
// Types of the genlock loop register bank
package glc_pkg;

   typedef enum logic [1:0] {
      LS_IDLE = 2'b00,
      LS_CRASH = 2'b01,
      LS_LOCKING = 2'b10,
      LS_LOCKED = 2'b11
   } glc_phase_e;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } glc_avs_req_s;

   typedef struct packed {
      logic valid;
      logic [31:0] num;
      logic [31:0] den;
   } glc_ratio_s;

   typedef struct packed {
      logic [31:0] num;
      logic [31:0] den;
      logic [15:0] ctrl;
   } glc_dflt_s;

   typedef struct packed {
      logic ack;
      logic wreq;
      logic [31:0] rdata;
      logic [31:0] num;
      logic [31:0] den;
      logic [15:0] ctrl;
      logic [1:0] std;
      logic [3:0] stat;
      logic [3:0] mask;
      glc_phase_e phase;
      logic [9:0] ccnt;
      logic [2:0] miss;
      logic seen;
      logic [4:0] good;
      logic irq;
      logic crash;
      logic lost;
      glc_ratio_s ratio;
   } glc_state_s;

endpackage

// >>> rtl/glc_regs.sv
// Genlock loop configuration registers with Avalon-MM slave and lock sequencer
//
// Function
// [R1] Nonzero denominator divides the video clock ratio
// [R2] Denominator split: low half, then high half
// [R3] Software strobes update bit to apply ratio
// [R4] Denominator defaults follow the selected standard
// [R5] Crash phase lasts crash field times four plus one
// [R6] Threshold field sets lock indication delay
// [R7] Tolerance field rides through missing reference pulses
// [R8] Zero tolerance reacts to any disturbance
// [R9] Control fields default per selected standard
// [R10] Nonzero split numerator is the ratio dividend
// [R11] Reserved word ignores writes, reads zero
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`include "glc_consts.svh"
module glc_regs (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Avalon-MM slave
   input wire glc_pkg::glc_avs_req_s AVS_REQ,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Horizontal reference
   input wire logic HREF_PULSE,
   input wire logic H_EXPECT,
   // Loop control
   output glc_pkg::glc_ratio_s RATIO,
   output logic CRASH_ACTIVE,
   output logic LOCK_LOST,
   output logic IRQ
);
   import glc_pkg::*;

   glc_state_s s_r;
   glc_state_s s_nxt;
   logic [5:0] idx;
   logic acc_wr;
   logic acc_rd;
   logic [3:0] ev;
   logic [3:0] clr;
   logic seen_now;
   logic miss_evt;
   logic [4:0] good_inc;
   logic [7:0] crash_f;
   logic [4:0] thr_f;
   logic [2:0] tol_f;
   glc_dflt_s dv;

   function automatic glc_dflt_s dflt(input logic [1:0] std);
      glc_dflt_s d;
      case (std)
         2'h0: d = '{`GLC_DEF_NUM_0, `GLC_DEF_DEN_0, `GLC_DEF_CTRL_0};
         2'h1: d = '{`GLC_DEF_NUM_1, `GLC_DEF_DEN_1, `GLC_DEF_CTRL_1};
         2'h2: d = '{`GLC_DEF_NUM_2, `GLC_DEF_DEN_2, `GLC_DEF_CTRL_2};
         default: d = '{`GLC_DEF_NUM_3, `GLC_DEF_DEN_3, `GLC_DEF_CTRL_3};
      endcase
      return d;
   endfunction

   // Byte-lane merge into a 16-bit register
   function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
      return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   function automatic logic [31:0] rd_word(input glc_state_s s, input logic [5:0] i);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (i)
         `GLC_IDX_NUM_LO: r[15:0] = s.num[15:0];
         `GLC_IDX_NUM_HI: r[15:0] = s.num[31:16];
         `GLC_IDX_DEN_LO: r[15:0] = s.den[15:0];
         `GLC_IDX_DEN_HI: r[15:0] = s.den[31:16];
         `GLC_IDX_CTRL: r[15:0] = s.ctrl;
         `GLC_IDX_STD: r[1:0] = s.std;
         `GLC_IDX_STAT: r[3:0] = s.stat;
         `GLC_IDX_MASK: r[3:0] = s.mask;
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   assign idx = AVS_REQ.address[7:2];
   // Access completes on the edge where waitrequest is low
   assign acc_wr = AVS_REQ.write & s_r.ack;
   assign acc_rd = AVS_REQ.read & s_r.ack;
   assign crash_f = s_r.ctrl[`GLC_CRASH_MSB:`GLC_CRASH_LSB];
   assign thr_f = s_r.ctrl[`GLC_THR_MSB:`GLC_THR_LSB];
   assign tol_f = s_r.ctrl[`GLC_TOL_MSB:`GLC_TOL_LSB];
   assign seen_now = s_r.seen | HREF_PULSE;
   // A second edge in one window counts as mis-timed
   assign miss_evt = (H_EXPECT & ~seen_now) | (HREF_PULSE & s_r.seen);
   assign good_inc = (s_r.good == 5'h1f) ? s_r.good : s_r.good + 5'h01;

   always_comb begin
      s_nxt = s_r;
      ev = 4'h0;
      clr = 4'h0;
      dv = dflt(s_r.std);
      // One wait cycle, then one ready cycle
      s_nxt.ack = (AVS_REQ.read | AVS_REQ.write) & ~s_r.ack;
      s_nxt.rdata = rd_word(s_r, idx);

      case (s_r.phase)
         LS_IDLE: s_nxt.phase = LS_IDLE;
         LS_CRASH: begin
            if (HREF_PULSE) begin
               if (s_r.ccnt == {crash_f, 2'b00}) begin // [R5]
                  s_nxt.phase = LS_LOCKING;
                  s_nxt.seen = 1'b0;
                  s_nxt.miss = 3'h0;
                  s_nxt.good = 5'h00;
                  ev[`GLC_EV_CRASH_DONE] = 1'b1;
               end else begin
                  s_nxt.ccnt = s_r.ccnt + 10'h001;
               end
            end
         end
         LS_LOCKING, LS_LOCKED: begin
            if (HREF_PULSE) begin
               s_nxt.seen = 1'b1;
            end
            if (miss_evt) begin
               if (s_r.miss >= tol_f) begin // [R7] [R8]
                  s_nxt.miss = 3'h0;
                  s_nxt.good = 5'h00;
                  s_nxt.phase = LS_LOCKING;
                  ev[`GLC_EV_LOCK_LOST] = (s_r.phase == LS_LOCKED);
               end else begin
                  s_nxt.miss = s_r.miss + 3'h1; // [R7]
               end
            end else if (H_EXPECT) begin
               s_nxt.miss = 3'h0;
               s_nxt.good = good_inc;
               if (s_r.phase == LS_LOCKING && good_inc >= thr_f) begin // [R6]
                  s_nxt.phase = LS_LOCKED;
               end
            end
            if (H_EXPECT) begin
               s_nxt.seen = 1'b0;
            end
         end
         default: s_nxt.phase = LS_IDLE;
      endcase

      // Bus writes come last so a restart beats the sequencer
      if (acc_wr) begin
         case (idx)
            `GLC_IDX_NUM_LO: s_nxt.num[15:0] = lane16(s_r.num[15:0], AVS_REQ.writedata,
                                                      AVS_REQ.byteenable); // [R10]
            `GLC_IDX_NUM_HI: s_nxt.num[31:16] = lane16(s_r.num[31:16], AVS_REQ.writedata,
                                                       AVS_REQ.byteenable); // [R10]
            `GLC_IDX_DEN_LO: s_nxt.den[15:0] = lane16(s_r.den[15:0], AVS_REQ.writedata,
                                                      AVS_REQ.byteenable); // [R2]
            `GLC_IDX_DEN_HI: s_nxt.den[31:16] = lane16(s_r.den[31:16], AVS_REQ.writedata,
                                                       AVS_REQ.byteenable); // [R2]
            `GLC_IDX_CTRL: s_nxt.ctrl = lane16(s_r.ctrl, AVS_REQ.writedata,
                                               AVS_REQ.byteenable);
            `GLC_IDX_UPDATE: begin
               // Staged words stay inert until this strobe
               if (AVS_REQ.byteenable[0] && AVS_REQ.writedata[`GLC_UPD_BIT]) begin // [R3]
                  if (s_r.num != 32'h0 && s_r.den != 32'h0) begin // [R1] [R10]
                     s_nxt.ratio = '{1'b1, s_r.num, s_r.den};
                     s_nxt.phase = LS_CRASH;
                     s_nxt.ccnt = 10'h000;
                     ev[`GLC_EV_APPLIED] = 1'b1;
                  end else begin
                     ev[`GLC_EV_REJECT] = 1'b1;
                  end
               end
            end
            `GLC_IDX_STD: begin
               if (AVS_REQ.byteenable[0]) begin
                  dv = dflt(AVS_REQ.writedata[1:0]);
                  s_nxt.std = AVS_REQ.writedata[1:0];
                  s_nxt.num = dv.num;
                  s_nxt.den = dv.den; // [R4]
                  s_nxt.ctrl = dv.ctrl; // [R9]
                  s_nxt.ratio = '{1'b1, dv.num, dv.den};
                  s_nxt.phase = LS_CRASH;
                  s_nxt.ccnt = 10'h000;
                  ev[`GLC_EV_APPLIED] = 1'b1;
               end
            end
            `GLC_IDX_STAT: clr = AVS_REQ.byteenable[0] ? AVS_REQ.writedata[3:0] : 4'h0;
            `GLC_IDX_MASK: begin
               if (AVS_REQ.byteenable[0]) begin
                  s_nxt.mask = AVS_REQ.writedata[3:0];
               end
            end
            default: s_nxt.mask = s_r.mask; // [R11]
         endcase
      end

      // A new event outweighs a clear in the same cycle
      s_nxt.stat = (s_r.stat & ~clr) | ev;
      s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
      // Decoded one cycle early so every output leaves straight from a flop
      s_nxt.wreq = ~s_nxt.ack;
      s_nxt.crash = (s_nxt.phase == LS_CRASH);
      s_nxt.lost = (s_nxt.phase != LS_LOCKED);
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         s_r <= '0;
         s_r.std <= `GLC_STD_RST;
         s_r.num <= `GLC_DEF_NUM_0;
         s_r.den <= `GLC_DEF_DEN_0; // [R4]
         s_r.ctrl <= `GLC_DEF_CTRL_0; // [R9]
         s_r.ratio <= '{1'b1, `GLC_DEF_NUM_0, `GLC_DEF_DEN_0};
         s_r.phase <= LS_CRASH;
         s_r.wreq <= 1'b1;
         s_r.crash <= 1'b1;
         s_r.lost <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign AVS_READDATA = s_r.rdata;
   assign AVS_WAITREQUEST = s_r.wreq;
   assign RATIO = s_r.ratio;
   assign CRASH_ACTIVE = s_r.crash;
   assign LOCK_LOST = s_r.lost;
   assign IRQ = s_r.irq;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   sequence s_wr(logic [5:0] i);
      AVS_REQ.write && !AVS_WAITREQUEST && idx == i && AVS_REQ.byteenable[1:0] == 2'b11;
   endsequence

   // A restart written in the same cycle overrides the crash end
   sequence s_crash_end;
      s_r.phase == LS_CRASH && HREF_PULSE && s_r.ccnt == {crash_f, 2'b00}
         && !(acc_wr && (idx == `GLC_IDX_UPDATE || idx == `GLC_IDX_STD));
   endsequence

   sequence s_apply;
      acc_wr && idx == `GLC_IDX_UPDATE && AVS_REQ.byteenable[0]
         && AVS_REQ.writedata[`GLC_UPD_BIT];
   endsequence

   // Defaults of the standard now in force
   glc_dflt_s chk_d;
   assign chk_d = dflt(s_r.std);

   a_ratio_nonzero: assert property (RATIO.valid |-> RATIO.den != 32'h0) // [R1]
      else $error("applied denominator is zero");

   a_update_refuse: assert property ( // [R1]
      s_apply ##0 (s_r.num == 32'h0 || s_r.den == 32'h0) |=> $stable(RATIO))
      else $error("zero ratio term was applied");

   a_den_low_half: assert property ( // [R2]
      s_wr(`GLC_IDX_DEN_LO) |=>
      s_r.den[15:0] == $past(AVS_REQ.writedata[15:0]) && $stable(s_r.den[31:16]))
      else $error("denominator low half not written");

   a_den_high_half: assert property ( // [R2]
      s_wr(`GLC_IDX_DEN_HI) |=>
      s_r.den[31:16] == $past(AVS_REQ.writedata[15:0]) && $stable(s_r.den[15:0]))
      else $error("denominator high half not written");

   a_ratio_hold: assert property ( // [R3]
      !(acc_wr && (idx == `GLC_IDX_UPDATE || idx == `GLC_IDX_STD)) |=> $stable(RATIO))
      else $error("ratio changed without strobe");

   a_num_high_half: assert property ( // [R10]
      s_wr(`GLC_IDX_NUM_HI) |=> s_r.num[31:16] == $past(AVS_REQ.writedata[15:0]))
      else $error("numerator high half not written");

   a_reset_defaults: assert property ($past(RST) |-> s_r.std == `GLC_STD_RST // [R4]
      && s_r.den == `GLC_DEF_DEN_0 && s_r.ctrl == `GLC_DEF_CTRL_0
      && RATIO.den == `GLC_DEF_DEN_0)
      else $error("reset defaults do not match standard");

   a_std_reload: assert property (s_wr(`GLC_IDX_STD) |=> // [R9]
      s_r.ctrl == chk_d.ctrl && s_r.den == chk_d.den && RATIO.num == chk_d.num)
      else $error("standard change did not reload defaults");

   a_crash_start: assert property ( // [R5]
      s_apply ##0 (s_r.num != 32'h0 && s_r.den != 32'h0) |=>
      CRASH_ACTIVE && s_r.ccnt == 10'h000)
      else $error("crash phase did not restart");

   a_crash_length: assert property (s_crash_end |=> // [R5]
      s_r.phase == LS_LOCKING && CRASH_ACTIVE == 1'b0)
      else $error("crash phase length wrong");

   a_lock_thresh: assert property ($rose(s_r.phase == LS_LOCKED) |-> // [R6]
      s_r.good >= $past(thr_f) && !LOCK_LOST)
      else $error("lock declared below threshold");

   a_tol_ride: assert property (s_r.phase == LS_LOCKED && tol_f != 3'h0 // [R7]
      && s_r.miss == 3'h0 && miss_evt && !acc_wr |=> !LOCK_LOST ##0 s_r.miss == 3'h1)
      else $error("single missing pulse dropped lock");

   a_tol_zero: assert property (s_r.phase == LS_LOCKED && tol_f == 3'h0 && miss_evt // [R8]
      && !acc_wr |=> LOCK_LOST && s_r.good == 5'h00)
      else $error("zero tolerance did not react at once");

   a_reserved_slot_zero: assert property (AVS_REQ.read && !AVS_WAITREQUEST // [R11]
      && idx == `GLC_IDX_RESERVED_SLOT |-> AVS_READDATA == 32'h0000_0000)
      else $error("reserved word read nonzero");

   a_reserved_slot_write: assert property (acc_wr && idx == `GLC_IDX_RESERVED_SLOT |=> // [R11]
      $stable(s_r.num) && $stable(s_r.den) && $stable(s_r.ctrl) && $stable(s_r.mask)
      && $stable(RATIO))
      else $error("reserved write changed a register");

   a_one_wait: assert property ((AVS_REQ.read || AVS_REQ.write) && AVS_WAITREQUEST |=>
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("bus answer not after one wait state");

endmodule

// >>> verification/glc_href_src.sv
// Horizontal reference source facing the genlock sequencer
`timescale 1ns/1ps
module glc_href_src (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control from bench
   input wire logic run,
   input wire logic drop,
   // Reference outputs
   output logic href,
   output logic hexp
);
   logic [2:0] ph_r;
   logic skip_r;
   // Eight-cycle line, pulse mid-window, window closes at phase 6
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         ph_r <= 3'h0;
         skip_r <= 1'b0;
      end else begin
         ph_r <= ph_r + 3'h1;
         if (drop) begin
            skip_r <= 1'b1;
         end else if (ph_r == 3'h2) begin
            skip_r <= 1'b0;
         end
      end
   end
   // Quiet outside a run so no stray edge reaches the loop
   assign href = run && ph_r == 3'h2 && !skip_r;
   assign hexp = run && ph_r == 3'h6;
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the genlock loop register bank
`timescale 1ns/1ps
`include "glc_consts.svh"
module tb_top;
   import glc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic run = 1'b0;
   logic drop = 1'b0;
   logic href, hexp, wreq, crash, lost, irq;
   logic [31:0] rd;
   glc_avs_req_s req = '0;
   glc_ratio_s ratio;
   int num_errors = 0;
   int checked = 0;
   logic [31:0] dn [4] = '{`GLC_DEF_NUM_0, `GLC_DEF_NUM_1, `GLC_DEF_NUM_2, `GLC_DEF_NUM_3};
   logic [31:0] dd [4] = '{`GLC_DEF_DEN_0, `GLC_DEF_DEN_1, `GLC_DEF_DEN_2, `GLC_DEF_DEN_3};
   logic [15:0] dc [4] = '{`GLC_DEF_CTRL_0, `GLC_DEF_CTRL_1, `GLC_DEF_CTRL_2, `GLC_DEF_CTRL_3};

   always #2.5 clk = ~clk;

   glc_regs i_glc_regs (.SYS_CLK(clk), .RST(rst), .AVS_REQ(req), .AVS_READDATA(rd),
      .AVS_WAITREQUEST(wreq), .HREF_PULSE(href), .H_EXPECT(hexp), .RATIO(ratio),
      .CRASH_ACTIVE(crash), .LOCK_LOST(lost), .IRQ(irq));
   glc_href_src i_glc_href_src (.clk(clk), .rst(rst), .run(run), .drop(drop),
      .href(href), .hexp(hexp));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      req.read <= !wr;
      req.write <= wr;
      req.address <= {idx, 2'b00};
      req.writedata <= {16'h0, d};
      req.byteenable <= 4'hf;
      // The edges to the answer are counted and checked against two; the watchdog ends a hang
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0);
      chk("edges to answer", 32'd2, n);
      q = rd;
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask

   task automatic rdc(input string what, input logic [5:0] idx, input logic [15:0] e);
      logic [31:0] q;
      bus(1'b0, idx, 16'h0, q);
      chk(what, {16'h0, e}, q);
   endtask

   task automatic t_std(input int s);
      rdc("num low", `GLC_IDX_NUM_LO, dn[s][15:0]);
      rdc("den low", `GLC_IDX_DEN_LO, dd[s][15:0]);
      rdc("den high", `GLC_IDX_DEN_HI, dd[s][31:16]);
      rdc("control", `GLC_IDX_CTRL, dc[s]);
      chk("applied den", dd[s], ratio.den);
      chk("applied num", dn[s], ratio.num);
      chk("ratio valid", 32'h1, {31'h0, ratio.valid});
      chk("crash restarted", 32'h1, {31'h0, crash});
   endtask

   task automatic t_ratio;
      wr(`GLC_IDX_STAT, 16'h000f);
      wr(`GLC_IDX_NUM_LO, 16'h5678);
      wr(`GLC_IDX_NUM_HI, 16'h1234);
      wr(`GLC_IDX_DEN_LO, 16'h0002);
      wr(`GLC_IDX_DEN_HI, 16'h0009);
      chk("num before strobe", dn[0], ratio.num);
      rdc("num high half", `GLC_IDX_NUM_HI, 16'h1234);
      rdc("den low half", `GLC_IDX_DEN_LO, 16'h0002);
      wr(`GLC_IDX_UPDATE, 16'h0040);
      repeat (2) @(posedge clk);
      chk("applied num", 32'h1234_5678, ratio.num);
      chk("applied den", 32'h0009_0002, ratio.den);
      rdc("status applied", `GLC_IDX_STAT, 16'h0001);
   endtask

   task automatic t_refuse;
      wr(`GLC_IDX_STAT, 16'h000f);
      wr(`GLC_IDX_DEN_LO, 16'h0000);
      wr(`GLC_IDX_DEN_HI, 16'h0000);
      wr(`GLC_IDX_UPDATE, 16'h0040);
      repeat (2) @(posedge clk);
      chk("zero den kept out", 32'h0009_0002, ratio.den);
      rdc("status refused", `GLC_IDX_STAT, 16'h0008);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`GLC_IDX_MASK, 16'h0008);
      repeat (2) @(posedge clk);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(`GLC_IDX_STAT, 16'h0008);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(`GLC_IDX_MASK, 16'h0000);
   endtask

   task automatic t_reserved;
      wr(`GLC_IDX_RESERVED_SLOT, 16'hffff);
      rdc("reserved", `GLC_IDX_RESERVED_SLOT, 16'h0000);
      rdc("unmapped", 6'h3f, 16'h0000);
      rdc("control kept", `GLC_IDX_CTRL, dc[0]);
   endtask

   task automatic watch(output int hi);
      hi = 0;
      repeat (48) begin
         @(posedge clk);
         if (lost !== 1'b0) hi++;
      end
   endtask

   task automatic t_lock;
      int n, h;
      n = 0;
      // Crash 1, threshold 2, tolerance 1
      wr(`GLC_IDX_CTRL, 16'h0111);
      wr(`GLC_IDX_DEN_LO, 16'h0003);
      wr(`GLC_IDX_UPDATE, 16'h0040);
      run <= 1'b1;
      repeat (120) begin
         @(posedge clk);
         if (crash === 1'b1 && href === 1'b1) n++;
      end
      chk("crash pulses", 32'd5, n);
      chk("locked", 32'h0, {31'h0, lost});
      rdc("status locked", `GLC_IDX_STAT, 16'h0003);
      drop <= 1'b1;
      @(posedge clk);
      drop <= 1'b0;
      watch(h);
      chk("rides one gap", 32'h0, h);
      wr(`GLC_IDX_CTRL, 16'h0110);
      drop <= 1'b1;
      @(posedge clk);
      drop <= 1'b0;
      watch(h);
      chk("zero tolerance reacts", 32'h1, {31'h0, h != 0});
      rdc("status lock lost", `GLC_IDX_STAT, 16'h0007);
      run <= 1'b0;
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Whole run is near four hundred cycles; this is about fifty times that
   initial begin
      #100000;
      num_errors++;
      tally_and_finish();
   end

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_std(0);
      for (int s = 3; s >= 0; s--) begin
         wr(`GLC_IDX_STD, 16'(s));
         t_std(s);
      end
      t_ratio();
      t_refuse();
      t_reserved();
      t_lock();
      tally_and_finish();
   end
endmodule
